//--- cbl_cfg_ram.v
// Configuration register store, filled from the registry image at self-boot.
// Assumes one clock; write port from the boot loader, read data registered.
`timescale 1ns/1ps

module cbl_cfg_ram #(
  parameter WIDTH = 8,   // Bits per registry byte
  parameter DEPTH = 63,  // Registry image size
  parameter AW    = 6    // Address width
) (
  input  wire             ref_clk,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Configuration registers

  // Write port and registered read port
  always @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

//--- cbl_defines.vh
// Constants for the calibration bank locator: memory map, pointer, slot format.
// Assumes inclusion by cbl_top.v and the bench, not by cbl_cfg_ram.v; holds definitions only.
`ifndef CBL_DEFINES_VH
`define CBL_DEFINES_VH

// ----------------------------------------------------------------------------
// Program memory map
// ----------------------------------------------------------------------------
`define CBL_PTR_ADDR      12'h210   // First byte of bank pointer word
`define CBL_PTR_BYTES     6'd4      // Pointer word length in bytes
`define CBL_BANK0_BASE    12'h217   // First slot of bank 0
`define CBL_BANK_STRIDE   12'h09a   // Distance between banks
`define CBL_BANK_COUNT    4'd9      // Banks 0 to 8
`define CBL_SLOT_STRIDE   12'h008   // Four value bytes then four code bytes
`define CBL_SLOT_BYTES    6'd4      // Value bytes per slot
`define CBL_SLOT_COUNT    5'd19     // Coefficient slots per bank
`define CBL_CFG_BASE      12'hfc0   // Configuration registry image start
`define CBL_CFG_LAST      12'hffe   // Configuration registry image end
`define CBL_CFG_BYTES     6'd63     // Bytes in the registry image

// ----------------------------------------------------------------------------
// Pointer and slot encoding
// ----------------------------------------------------------------------------
`define CBL_PTR_ALL_ONES  32'hffffffff  // Pointer selecting bank 0
`define CBL_BYTE_MARK     2'b11         // Top two bits of each value byte
`define CBL_MARK_HI       7
`define CBL_MARK_LO       6

// ----------------------------------------------------------------------------
// Memory access timing (cycles)
// ----------------------------------------------------------------------------
`define CBL_RD_LATENCY    2'd2      // Read pulse to sample of read data

`endif

//--- cbl_top.v
// Calibration bank locator: self-boot loader and coefficient slot access.
// Assumes a byte-wide program memory whose read data is valid two edges
// after the read pulse; writes take effect on the pulse.
//
// Function
// - Never overwrite; program replacement into next bank
// - Bank pointer word read from 210-213
// - Pointer ones-pattern selects banks zero to eight
// - Slot value bytes only; code bytes untouched
// - Slots repeat every eight bytes
// - Each coefficient has fixed fractional bit count
// - Value byte is 11 plus six bits
// - Coefficients are two's complement 24-bit values
// - Self-boot copies registry image into config registers
// - Device boots from nonvolatile memory after reset
`timescale 1ns/1ps
`include "cbl_defines.vh"

module cbl_top #(
  parameter AW = 12  // Program memory address width
) (
  input  wire          ref_clk,
  input  wire          reset,
  output reg  [AW-1:0] mem_addr,
  output reg           mem_rd,
  output reg           mem_wr,
  output reg  [7:0]    mem_wdata,
  input  wire [7:0]    mem_rdata,
  input  wire          coef_rd_req,
  input  wire          coef_wr_req,
  input  wire          bank_adv_req,
  input  wire [4:0]    coef_index,
  input  wire [23:0]   coef_wvalue,
  input  wire [5:0]    cfg_raddr,
  output wire [7:0]    cfg_rdata,
  output reg           boot_done,
  output reg           busy,
  output reg  [3:0]    bank_sel,
  output reg  [23:0]   coef_value,
  output reg  [4:0]    coef_frac,
  output reg           coef_valid,
  output reg           coef_err
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam S_PTR  = 3'd0;  // Fetch pointer word
  localparam S_CFG  = 3'd1;  // Copy registry image
  localparam S_IDLE = 3'd2;  // Wait for requests
  localparam S_RD   = 3'd3;  // Read a slot
  localparam S_WR   = 3'd4;  // Program a slot
  localparam S_ADV  = 3'd5;  // Program the pointer word

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Pointer word to bank number
  function [3:0] ptr_to_bank;
    input [31:0] ptr;
    integer n;
    begin
      ptr_to_bank = 4'd0;  // No pattern matched: bank 0
      for (n = 1; n < 9; n = n + 1) begin
        if (ptr == (`CBL_PTR_ALL_ONES << n)) begin
          ptr_to_bank = n[3:0];
        end
      end
    end
  endfunction

  // Fixed-point position of each slot
  function [4:0] frac_bits;
    input [4:0] idx;
    begin
      case (idx)
        5'd0, 5'd5:   frac_bits = 5'd22;
        5'd2:         frac_bits = 5'd14;
        5'd3:         frac_bits = 5'd19;
        5'd4, 5'd10:  frac_bits = 5'd21;
        5'd11, 5'd12: frac_bits = 5'd24;
        5'd15, 5'd17: frac_bits = 5'd1;
        default:      frac_bits = 5'd8;
      endcase
    end
  endfunction

  // Slot start address for a bank and index
  function [11:0] slot_addr;
    input [3:0] bank;
    input [4:0] idx;
    reg   [15:0] sum;
    begin
      sum = {4'h0, `CBL_BANK0_BASE} + ({12'h000, bank} * {4'h0, `CBL_BANK_STRIDE})
            + ({11'h000, idx} * {4'h0, `CBL_SLOT_STRIDE});
      slot_addr = sum[11:0];
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [2:0]  state;       // Sequencer state
  reg [5:0]  cnt;         // Byte counter within a transfer
  reg [1:0]  pend;        // Access phase: 0 issue, then wait
  reg [11:0] base;        // Start address of the transfer
  reg [31:0] shreg;       // Assembled bytes or bytes to write
  reg        bad;         // Malformed value byte seen
  reg        cfg_we;      // Registry store write
  reg [5:0]  cfg_waddr;   // Registry store address
  reg [7:0]  cfg_wdata;   // Registry store data
  reg [4:0]  idx;         // Slot being accessed
  reg [3:0]  new_bank;    // Bank being opened

  wire [3:0]  next_bank  = bank_sel + 4'd1;  // Next unused bank
  wire        last_bank  = (bank_sel == `CBL_BANK_COUNT - 4'd1);
  wire        idx_ok     = (coef_index < `CBL_SLOT_COUNT);
  wire [5:0]  len        = (state == S_CFG) ? `CBL_CFG_BYTES : `CBL_PTR_BYTES;
  wire        last_byte  = (cnt == len - 6'd1);
  wire [11:0] byte_addr  = base + {6'h00, cnt};

  // --------------------------------------------------------------------------
  // Registry store
  // --------------------------------------------------------------------------
  cbl_cfg_ram #(
    .WIDTH (8),
    .DEPTH (63),
    .AW    (6)
  ) u_cfg (
    .ref_clk (ref_clk),
    .we      (cfg_we),
    .waddr   (cfg_waddr),
    .wdata   (cfg_wdata),
    .raddr   (cfg_raddr),
    .rdata   (cfg_rdata)
  );

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Boot from pointer and registry, then serve slot requests
  always @(posedge ref_clk) begin
    if (reset) begin
      state      <= S_PTR;
      cnt        <= 6'd0;
      pend       <= 2'd0;
      base       <= `CBL_PTR_ADDR;
      shreg      <= 32'h00000000;
      bad        <= 1'b0;
      cfg_we     <= 1'b0;
      cfg_waddr  <= 6'd0;
      cfg_wdata  <= 8'h00;
      idx        <= 5'd0;
      new_bank   <= 4'd0;
      mem_addr   <= {AW{1'b0}};
      mem_rd     <= 1'b0;
      mem_wr     <= 1'b0;
      mem_wdata  <= 8'h00;
      boot_done  <= 1'b0;
      busy       <= 1'b1;
      bank_sel   <= 4'd0;
      coef_value <= 24'h000000;
      coef_frac  <= 5'd0;
      coef_valid <= 1'b0;
      coef_err   <= 1'b0;
    end else begin
      mem_rd     <= 1'b0;
      mem_wr     <= 1'b0;
      cfg_we     <= 1'b0;
      coef_valid <= 1'b0;
      coef_err   <= 1'b0;
      case (state)
        // Read transfers: pointer, registry image, slot value
        S_PTR, S_CFG, S_RD: begin
          if (pend == 2'd0) begin
            mem_addr <= byte_addr[AW-1:0];
            mem_rd   <= 1'b1;
            pend     <= 2'd1;
          end else if (pend != `CBL_RD_LATENCY) begin
            pend <= pend + 2'd1;
          end else begin
            pend  <= 2'd0;
            cnt   <= cnt + 6'd1;
            shreg <= {shreg[23:0], mem_rdata};  // First byte most significant
            if (state == S_RD && mem_rdata[`CBL_MARK_HI:`CBL_MARK_LO] != `CBL_BYTE_MARK) begin
              bad <= 1'b1;
            end
            if (state == S_CFG) begin
              cfg_we    <= 1'b1;
              cfg_waddr <= cnt;
              cfg_wdata <= mem_rdata;
            end
            if (last_byte) begin
              cnt <= 6'd0;
              case (state)
                S_PTR: begin
                  bank_sel <= ptr_to_bank({shreg[23:0], mem_rdata});
                  base     <= `CBL_CFG_BASE;
                  state    <= S_CFG;
                end
                S_CFG: begin
                  boot_done <= 1'b1;
                  busy      <= 1'b0;
                  state     <= S_IDLE;
                end
                default: begin
                  // Six-bit groups joined into a signed 24-bit value
                  coef_value <= {shreg[21:16], shreg[13:8], shreg[5:0], mem_rdata[5:0]};
                  coef_frac  <= frac_bits(idx);
                  coef_valid <= 1'b1;
                  coef_err   <= bad | (mem_rdata[`CBL_MARK_HI:`CBL_MARK_LO] != `CBL_BYTE_MARK);
                  busy       <= 1'b0;
                  state      <= S_IDLE;
                end
              endcase
            end
          end
        end
        // Accept one request at a time
        S_IDLE: begin
          if (coef_rd_req) begin
            if (idx_ok) begin
              idx   <= coef_index;
              base  <= slot_addr(bank_sel, coef_index);
              bad   <= 1'b0;
              busy  <= 1'b1;
              state <= S_RD;
            end else begin
              coef_err <= 1'b1;  // Unknown slot
            end
          end else if (coef_wr_req) begin
            if (idx_ok && !last_bank) begin
              idx   <= coef_index;
              base  <= slot_addr(next_bank, coef_index);
              shreg <= {`CBL_BYTE_MARK, coef_wvalue[23:18], `CBL_BYTE_MARK, coef_wvalue[17:12],
                        `CBL_BYTE_MARK, coef_wvalue[11:6], `CBL_BYTE_MARK, coef_wvalue[5:0]};
              busy  <= 1'b1;
              state <= S_WR;
            end else begin
              coef_err <= 1'b1;  // Unknown slot or no unused bank left
            end
          end else if (bank_adv_req) begin
            if (!last_bank) begin
              new_bank <= next_bank;
              base     <= `CBL_PTR_ADDR;
              shreg    <= `CBL_PTR_ALL_ONES << next_bank;
              busy     <= 1'b1;
              state    <= S_ADV;
            end else begin
              coef_err <= 1'b1;
            end
          end
        end
        // Write transfers: four value bytes or the pointer word, code bytes never touched
        S_WR, S_ADV: begin
          if (pend == 2'd0) begin
            mem_addr  <= byte_addr[AW-1:0];
            mem_wdata <= shreg[31:24];
            mem_wr    <= 1'b1;
            pend      <= 2'd1;
          end else begin
            pend  <= 2'd0;
            shreg <= {shreg[23:0], 8'h00};
            cnt   <= cnt + 6'd1;
            if (last_byte) begin
              cnt   <= 6'd0;
              busy  <= 1'b0;
              state <= S_IDLE;
              if (state == S_ADV) begin
                bank_sel <= new_bank;
              end
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

//--- cbl_top_properties.sv
// Concurrent checks on the ports of the calibration bank locator.
// Assumes the single ref_clk domain of cbl_top; bound at the foot of this file.
`timescale 1ns/1ps

module cbl_top_properties #(
  parameter AW = 12  // Program memory address width
) (
  input logic          ref_clk,
  input logic          reset,
  input logic [AW-1:0] mem_addr,
  input logic          mem_rd,
  input logic          mem_wr,
  input logic [7:0]    mem_wdata,
  input logic          coef_rd_req,
  input logic          coef_wr_req,
  input logic          bank_adv_req,
  input logic [4:0]    coef_index,
  input logic          boot_done,
  input logic          busy,
  input logic [3:0]    bank_sel,
  input logic          coef_valid,
  input logic          coef_err
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Value byte of a slot: banks are 0x9a apart, so the low bits move per bank
  function automatic logic val_byte(input logic [11:0] s);
    int o;
    o = (int'(s) - 'h217) % 'h9a;
    return s >= 12'h217 && s <= 12'h780 && (o % 8) < 4 && o < 152;
  endfunction
  // ---------------------------------------------------------------------------
  // Request steps
  // ---------------------------------------------------------------------------
  sequence s_idle;
    !busy && boot_done;
  endsequence
  sequence s_take_rd;
    s_idle ##0 coef_rd_req && coef_index < 5'h13;
  endsequence
  sequence s_take_bad;
    s_idle ##0 (coef_rd_req || coef_wr_req) && coef_index >= 5'h13;
  endsequence
  sequence s_take_adv_last;
    s_idle ##0 bank_adv_req && !coef_rd_req && !coef_wr_req && bank_sel == 4'h8;
  endsequence
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  AST_BOOT_START: assert property ($fell(reset) |=> mem_rd && mem_addr == 12'h210)
    else $error("boot did not start at pointer word");
  AST_BUSY_BOOT: assert property (!boot_done |-> busy)
    else $error("idle before boot finished");
  AST_DONE_HOLD: assert property (boot_done |=> boot_done)
    else $error("boot done dropped");
  AST_RD_GAP: assert property (mem_rd |=> !mem_rd [*2])
    else $error("reads closer than three cycles");
  AST_WR_GAP: assert property (mem_wr |=> !mem_wr)
    else $error("writes back to back");
  AST_WR_MARK: assert property (mem_wr && !(mem_addr inside {[12'h210:12'h213]}) |-> mem_wdata[7:6] == 2'b11)
    else $error("slot byte without mark bits");
  AST_WR_SLOT: assert property (mem_wr && mem_addr >= 12'h214 |-> val_byte(mem_addr))
    else $error("write outside value bytes");
  AST_READ_LAT: assert property (s_take_rd |=> busy ##12 coef_valid)
    else $error("slot read latency wrong");
  AST_REFUSE: assert property (s_take_bad |=> coef_err && !busy)
    else $error("bad index not refused");
  AST_ADV_LAST: assert property (s_take_adv_last |=> coef_err && bank_sel == 4'h8)
    else $error("advance past last bank");
  AST_BANK_STEP: assert property (boot_done && $changed(bank_sel) |-> bank_sel == $past(bank_sel) + 4'h1)
    else $error("bank select jumped");
  AST_VALID_PULSE: assert property (coef_valid |=> !coef_valid)
    else $error("valid longer than one cycle");
endmodule

bind cbl_top cbl_top_properties #(.AW(AW)) i_props (.ref_clk(ref_clk), .reset(reset), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .coef_rd_req(coef_rd_req), .coef_wr_req(coef_wr_req),
  .bank_adv_req(bank_adv_req), .coef_index(coef_index), .boot_done(boot_done), .busy(busy), .bank_sel(bank_sel),
  .coef_valid(coef_valid), .coef_err(coef_err));

//--- tb_calibration_bank_locator.sv
// Self-checking bench: program memory model, pointer decode, slot reads and writes.
// Assumes cbl_top and its defines; memory answers two edges after mem_rd.
`timescale 1ns/1ps
`include "cbl_defines.vh"

module tb_calibration_bank_locator;
  reg         ref_clk, reset, coef_rd_req, coef_wr_req, bank_adv_req, got_err, got_val;
  reg  [4:0]  coef_index, got_frac;
  reg  [23:0] coef_wvalue, v, got_value;
  reg  [5:0]  cfg_raddr;
  reg  [7:0]  mem_rdata;
  reg  [7:0]  mem [0:4095];  // Program memory image
  reg  [31:0] seed;          // Xorshift state
  wire [11:0] mem_addr;
  wire        mem_rd, mem_wr, boot_done, busy, coef_valid, coef_err;
  wire [7:0]  mem_wdata, cfg_rdata;
  wire [3:0]  bank_sel;
  wire [23:0] coef_value;
  wire [4:0]  coef_frac;
  integer     err_total, n_checks, cyc, i, n, w, a;
  // Writes may land only on pointer or slot value bytes
  wire        wr_ok = (mem_addr >= 12'h210 && mem_addr <= 12'h213) || val_byte(mem_addr);

  cbl_top i_dut (.ref_clk(ref_clk), .reset(reset), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .coef_rd_req(coef_rd_req), .coef_wr_req(coef_wr_req),
    .bank_adv_req(bank_adv_req), .coef_index(coef_index), .coef_wvalue(coef_wvalue), .cfg_raddr(cfg_raddr),
    .cfg_rdata(cfg_rdata), .boot_done(boot_done), .busy(busy), .bank_sel(bank_sel), .coef_value(coef_value),
    .coef_frac(coef_frac), .coef_valid(coef_valid), .coef_err(coef_err));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------------------
  // Memory model: data two edges after the pulse, toggling garbage otherwise
  // ---------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    cyc <= cyc + 1;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
      check(wr_ok, 1);
    end
    if (cyc == 20000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [4:0] frac_of(input [4:0] k);
    reg [94:0] t;
    begin
      t = {5'h08, 5'h01, 5'h08, 5'h01, 5'h08, 5'h08, 5'h18, 5'h18, 5'h15, 5'h08,
           5'h08, 5'h08, 5'h08, 5'h16, 5'h15, 5'h13, 5'h0e, 5'h08, 5'h16};
      frac_of = t[k*5 +: 5];
    end
  endfunction
  function [11:0] slot(input [3:0] b, input [4:0] k);
    slot = `CBL_BANK0_BASE + b * `CBL_BANK_STRIDE + k * `CBL_SLOT_STRIDE;
  endfunction
  function [23:0] dec(input [11:0] s);
    dec = {mem[s][5:0], mem[s+1][5:0], mem[s+2][5:0], mem[s+3][5:0]};
  endfunction
  // Value byte of any slot of any bank, code bytes excluded
  function val_byte(input [11:0] s);
    integer o;
    begin
      o = (s - `CBL_BANK0_BASE) % `CBL_BANK_STRIDE;
      val_byte = s >= `CBL_BANK0_BASE && s <= 12'h780 && (o % 8) < 4 && o < 152;
    end
  endfunction
  task automatic check(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Wait until idle, catching the result pulses on the way
  task settle;
    begin
      got_err = 1'b0;
      got_val = 1'b0;
      w = 0;
      while ((w < 3 || busy !== 1'b0) && w < 2000) begin
        @(posedge ref_clk);
        w = w + 1;
        if (coef_err === 1'b1) got_err = 1'b1;
        if (coef_valid === 1'b1) begin
          got_val = 1'b1;
          got_value = coef_value;
          got_frac = coef_frac;
        end
      end
      check(busy, 0);
    end
  endtask
  task req(input [2:0] kind, input [4:0] k, input [23:0] val);
    begin
      @(posedge ref_clk);
      {coef_rd_req, coef_wr_req, bank_adv_req} <= kind;
      coef_index <= k;
      coef_wvalue <= val;
      @(posedge ref_clk);
      {coef_rd_req, coef_wr_req, bank_adv_req} <= 3'h0;
      settle;
    end
  endtask
  task boot(input [31:0] p);
    begin
      {mem[12'h210], mem[12'h211], mem[12'h212], mem[12'h213]} = p;
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      settle;
    end
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {reset, coef_rd_req, coef_wr_req, bank_adv_req} = 4'h8;
    {coef_index, coef_wvalue, cfg_raddr, mem_rdata} = 0;
    {seed, err_total, n_checks, cyc} = {32'h54, 96'h0};
    for (i = 0; i < 4096; i = i + 1) begin
      seed = xs(seed);
      mem[i] = (i >= 12'hfc0) ? seed[7:0] : {2'b11, seed[5:0]};
    end
    for (i = 0; i < 10; i = i + 1) begin
      boot(i < 9 ? 32'hffffffff << i : 32'hffff0fff);
      check(bank_sel, i < 9 ? i : 0);
      if (i == 8) begin
        req(3'h1, 0, 0);
        check(got_err, 1);
      end
    end
    boot(32'hfffffffc);
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      @(posedge ref_clk);
      cfg_raddr <= 6'(seed % 63);
      repeat (2) @(posedge ref_clk);
      check(cfg_rdata, mem[`CBL_CFG_BASE + cfg_raddr]);
    end
    for (i = 0; i < 21; i = i + 1) begin
      req(3'h4, i[4:0], 0);
      check({got_val, got_err}, i < 19 ? 2'b10 : 2'b01);
      check(i < 19 ? got_value : coef_value, dec(slot(2, i < 19 ? i[4:0] : 5'd18)));
      check(i < 19 ? got_frac : coef_frac, frac_of(i < 19 ? i[4:0] : 5'd18));
    end
    check(mem_addr, 12'h34b + 12'h093);
    a = slot(2, 5);
    mem[a+2] = 8'h3f;
    req(3'h4, 5, 0);
    check(got_err, 1);
    for (i = 0; i < 3; i = i + 1) begin
      seed = xs(seed);
      v = (i == 2) ? 24'h800000 : seed[23:0];
      n = (i == 1) ? 18 : seed[28:24] % 19;
      a = slot(3, n[4:0]);
      req(3'h2, n[4:0], v);
      check({mem[a], mem[a+1], mem[a+2], mem[a+3]},
            {2'b11, v[23:18], 2'b11, v[17:12], 2'b11, v[11:6], 2'b11, v[5:0]});
    end
    req(3'h1, 0, 0);
    check(bank_sel, 3);
    check({mem[12'h210], mem[12'h211], mem[12'h212], mem[12'h213]}, 32'hfffffff8);
    req(3'h4, n[4:0], 0);
    check(got_value, v);
    finish_test;
  end
endmodule
